/* rtl/macu_mult.sv */
// Purpose: Combinational product term for each multiply form
// Assumes: Operands stable while the caller samples the result
// Notes:   Result is already sign extended or truncated to accumulator width
`timescale 1ns/1ps
`default_nettype none
module macu_mult (
    input  wire logic [1:0]                 sel_hl,
    input  wire logic [2:0]                 op,
    input  wire logic [macu_pkg::WORD_W-1:0] src_a,
    input  wire logic [macu_pkg::WORD_W-1:0] src_b,
    output logic      [macu_pkg::ACC_W-1:0]  term
);
    import macu_pkg::*;

    function automatic logic signed [HALF_W-1:0] pick(input logic [WORD_W-1:0] w,
                                                      input logic hi);
        pick = hi ? w[WORD_W-1:HALF_W] : w[HALF_W-1:0];
    endfunction

    logic signed [WORD_W-1:0]   p_sel;
    logic signed [WORD_W-1:0]   p_hi;
    logic signed [WORD_W-1:0]   p_lo;
    logic signed [2*WORD_W-1:0] p_word;

    always_comb begin
        p_sel  = pick(src_a, sel_hl[1]) * pick(src_b, sel_hl[0]);   // RL5
        p_hi   = pick(src_a, 1'b1) * pick(src_b, 1'b1);             // RL6
        p_lo   = pick(src_a, 1'b0) * pick(src_b, 1'b0);             // RL6
        p_word = $signed(src_a) * $signed(src_b);                   // RL7
        unique case (op)
            MACU_OP_HALF: term = ACC_W'(p_sel);                     // RL5
            MACU_OP_DUAL: term = ACC_W'(p_hi) + ACC_W'(p_lo);       // RL6
            MACU_OP_WORD: term = p_word[ACC_W-1:0];                 // RL7
            default:      term = '0;
        endcase
    end
endmodule
`default_nettype wire

/* rtl/macu_pkg.sv */
// Purpose: Shared constants and types for the multiply-accumulate unit
// Assumes: Signed two's complement operands from the core
// Notes:   Opcodes are local encodings of the issue port
package macu_pkg;
    localparam int ACC_W     = 40;
    localparam int WORD_W    = 32;
    localparam int HALF_W    = 16;
    localparam int HI_BITS_W = ACC_W - WORD_W;
    localparam logic [ACC_W-1:0] ACC_RESET = 40'h00_0000_0000;
    localparam int SLOW_CYCLES = 2;

    typedef enum logic [2:0] {
        MACU_OP_HALF,
        MACU_OP_DUAL,
        MACU_OP_WORD,
        MACU_OP_TO_CORE,
        MACU_OP_FROM_CORE,
        MACU_OP_STORE,
        MACU_OP_LOAD
    } macu_op_t;

    typedef enum logic {
        MACU_IDLE,
        MACU_BUSY
    } macu_state_t;
endpackage

/* rtl/macu_top.sv */
// Purpose: Multiply-accumulate coprocessor holding one 40-bit accumulator
// Assumes: Core holds op and operands steady until ack; one request at a time
// Notes:   Full 32x32 word form takes two cycles, all others one
// Notes on behaviour
// [RL1] One 40-bit accumulator serves signed 16x16, dual 16x16 and 32x32 accumulate forms.
// [RL2] The move to the core returns the accumulator as a low word and a sign-extended high word.
// [RL3] The move from the core loads the accumulator from a low word and the low 8 bits of a high word.
// [RL4] Saving or restoring the accumulator takes two transfers, low word first then high word.
// [RL5] The halfword form picks one half of each operand and adds the sign-extended product.
// [RL6] The dual form adds both sign-extended products of the high and low half pairs.
// [RL7] The word form adds only the 40 low bits of the 64-bit product.
// [RL8] Forms whose operand is effectively 16 by 32 bits finish in one cycle.
// [RL9] Accumulation wraps modulo two to the fortieth with no saturation or flag.
`timescale 1ns/1ps
`default_nettype none
module macu_top (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        req_valid,
    input  wire macu_pkg::macu_op_t          req_op,
    input  wire logic [1:0]                  req_sel_hl,
    input  wire logic [macu_pkg::WORD_W-1:0] req_a,
    input  wire logic [macu_pkg::WORD_W-1:0] req_b,
    output logic                             ack,
    output logic [macu_pkg::WORD_W-1:0]      rd_lo,
    output logic [macu_pkg::WORD_W-1:0]      rd_hi,
    output logic [macu_pkg::WORD_W-1:0]      xfer_data,
    output logic [macu_pkg::ACC_W-1:0]       acc_out
);
    import macu_pkg::*;

    typedef struct packed {
        macu_state_t          st;
        logic                 xfer_hi;
        logic [ACC_W-1:0]     acc;
        logic                 ack;
        logic [WORD_W-1:0]    rd_lo;
        logic [WORD_W-1:0]    rd_hi;
        logic [WORD_W-1:0]    xfer;
    } macu_state_s_t;

    macu_state_s_t s_q;
    macu_state_s_t s_d;
    logic [ACC_W-1:0] term;
    logic             short_word;
    logic             take;

    macu_mult u_mult (
        .sel_hl (req_sel_hl),
        .op     (req_op),
        .src_a  (req_a),
        .src_b  (req_b),
        .term   (term)
    );

    // First operand req_a that fits in 16 signed bits makes the word form single cycle
    assign short_word = (req_a[WORD_W-1:HALF_W-1] == '0)
                     || (req_a[WORD_W-1:HALF_W-1] == '1);

    // A request still standing while its own ack shows is not taken twice
    assign take = (s_q.st == MACU_IDLE) && req_valid && !s_q.ack;

    always_comb begin
        s_d     = s_q;
        s_d.ack = 1'b0;
        unique case (s_q.st)
            MACU_IDLE: begin
                if (take) begin
                    unique case (req_op)
                        MACU_OP_HALF, MACU_OP_DUAL: begin
                            s_d.acc = s_q.acc + term;                   // RL1 RL9
                            s_d.ack = 1'b1;                             // RL8
                        end
                        MACU_OP_WORD: begin
                            if (short_word) begin
                                s_d.acc = s_q.acc + term;               // RL8 RL9
                                s_d.ack = 1'b1;
                            end else begin
                                s_d.st = MACU_BUSY;
                            end
                        end
                        MACU_OP_TO_CORE: begin
                            s_d.rd_lo = s_q.acc[WORD_W-1:0];            // RL2
                            s_d.rd_hi = {{(WORD_W-HI_BITS_W){s_q.acc[ACC_W-1]}},
                                         s_q.acc[ACC_W-1:WORD_W]};      // RL2
                            s_d.ack   = 1'b1;
                        end
                        MACU_OP_FROM_CORE: begin
                            s_d.acc = {req_b[HI_BITS_W-1:0], req_a};    // RL3
                            s_d.ack = 1'b1;
                        end
                        MACU_OP_STORE: begin
                            s_d.xfer    = s_q.xfer_hi
                                ? {{(WORD_W-HI_BITS_W){s_q.acc[ACC_W-1]}},
                                   s_q.acc[ACC_W-1:WORD_W]}
                                : s_q.acc[WORD_W-1:0];                  // RL4
                            s_d.xfer_hi = ~s_q.xfer_hi;                 // RL4
                            s_d.ack     = 1'b1;
                        end
                        MACU_OP_LOAD: begin
                            if (s_q.xfer_hi) begin
                                s_d.acc[ACC_W-1:WORD_W] = req_a[HI_BITS_W-1:0];
                            end else begin
                                s_d.acc[WORD_W-1:0] = req_a;            // RL4
                            end
                            s_d.xfer_hi = ~s_q.xfer_hi;                 // RL4
                            s_d.ack     = 1'b1;
                        end
                        default: s_d.ack = 1'b1;
                    endcase
                    if (req_op != MACU_OP_STORE && req_op != MACU_OP_LOAD) begin
                        s_d.xfer_hi = 1'b0;
                    end
                end
            end
            MACU_BUSY: begin
                s_d.acc = s_q.acc + term;                               // RL7 RL9
                s_d.ack = 1'b1;
                s_d.st  = MACU_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q         <= '0;
            s_q.st      <= MACU_IDLE;
            s_q.acc     <= ACC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign ack       = s_q.ack;
    assign rd_lo     = s_q.rd_lo;
    assign rd_hi     = s_q.rd_hi;
    assign xfer_data = s_q.xfer;
    assign acc_out   = s_q.acc;

    // Checks
    property p_half_one_cycle;
        @(posedge core_clk) disable iff (rst)
        (take && req_op == MACU_OP_HALF) |=> ack;
    endproperty
    a_half_one_cycle: assert property (p_half_one_cycle) // RL8
        else $error("half mac not 1 cycle");

    property p_half_sum;
        @(posedge core_clk) disable iff (rst)
        (take && req_op == MACU_OP_HALF)
            |=> acc_out == $past(s_q.acc) + $past(term);
    endproperty
    a_half_sum: assert property (p_half_sum) // RL5
        else $error("half mac sum wrong");

    property p_dual_sum;
        @(posedge core_clk) disable iff (rst)
        (take && req_op == MACU_OP_DUAL)
            |=> acc_out == $past(s_q.acc) + $past(term);
    endproperty
    a_dual_sum: assert property (p_dual_sum) // RL6
        else $error("dual mac sum wrong");

    property p_word_short;
        @(posedge core_clk) disable iff (rst)
        (take && req_op == MACU_OP_WORD && short_word)
            |=> ack && acc_out == $past(s_q.acc) + $past(term);
    endproperty
    a_word_short: assert property (p_word_short) // RL8
        else $error("short word mac not 1 cycle");

    property p_word_two;
        @(posedge core_clk) disable iff (rst)
        (take && req_op == MACU_OP_WORD && !short_word)
            |=> !ack ##1 ack;
    endproperty
    a_word_two: assert property (p_word_two) // RL7
        else $error("word mac timing wrong");

    property p_word_sum;
        @(posedge core_clk) disable iff (rst)
        (s_q.st == MACU_BUSY)
            |=> ack && s_q.st == MACU_IDLE && acc_out == $past(s_q.acc) + $past(term);
    endproperty
    a_word_sum: assert property (p_word_sum) // RL7
        else $error("word mac sum wrong");

    property p_to_core;
        @(posedge core_clk) disable iff (rst)
        (take && req_op == MACU_OP_TO_CORE)
            |=> rd_lo == $past(s_q.acc[WORD_W-1:0])
                && rd_hi == {{(WORD_W-HI_BITS_W){$past(s_q.acc[ACC_W-1])}},
                             $past(s_q.acc[ACC_W-1:WORD_W])};
    endproperty
    a_to_core: assert property (p_to_core) // RL2
        else $error("move to core wrong");

    property p_from_core;
        @(posedge core_clk) disable iff (rst)
        (take && req_op == MACU_OP_FROM_CORE)
            |=> acc_out == {$past(req_b[HI_BITS_W-1:0]), $past(req_a)};
    endproperty
    a_from_core: assert property (p_from_core) // RL3
        else $error("move from core wrong");

    property p_store_order;
        @(posedge core_clk) disable iff (rst)
        (take && req_op == MACU_OP_STORE && !s_q.xfer_hi)
            |=> xfer_data == $past(s_q.acc[WORD_W-1:0]) && s_q.xfer_hi;
    endproperty
    a_store_order: assert property (p_store_order) // RL4
        else $error("store order wrong");

    property p_store_hi;
        @(posedge core_clk) disable iff (rst)
        (take && req_op == MACU_OP_STORE && s_q.xfer_hi)
            |=> !s_q.xfer_hi && xfer_data == {{(WORD_W-HI_BITS_W){$past(s_q.acc[ACC_W-1])}},
                                              $past(s_q.acc[ACC_W-1:WORD_W])};
    endproperty
    a_store_hi: assert property (p_store_hi) // RL4
        else $error("store high word wrong");

    property p_load_lo;
        @(posedge core_clk) disable iff (rst)
        (take && req_op == MACU_OP_LOAD && !s_q.xfer_hi)
            |=> s_q.xfer_hi && acc_out == {$past(s_q.acc[ACC_W-1:WORD_W]), $past(req_a)};
    endproperty
    a_load_lo: assert property (p_load_lo) // RL4
        else $error("load low word wrong");

    property p_load_hi;
        @(posedge core_clk) disable iff (rst)
        (take && req_op == MACU_OP_LOAD && s_q.xfer_hi)
            |=> !s_q.xfer_hi
                && acc_out == {$past(req_a[HI_BITS_W-1:0]), $past(s_q.acc[WORD_W-1:0])};
    endproperty
    a_load_hi: assert property (p_load_hi) // RL4
        else $error("load high word wrong");

    property p_phase_clear;
        @(posedge core_clk) disable iff (rst)
        (take && req_op != MACU_OP_STORE && req_op != MACU_OP_LOAD) |=> !s_q.xfer_hi;
    endproperty
    a_phase_clear: assert property (p_phase_clear) // RL4
        else $error("transfer phase not cleared");

    property p_one_acc;
        @(posedge core_clk) disable iff (rst)
        ack |-> $past(take) || $past(s_q.st == MACU_BUSY);
    endproperty
    a_one_acc: assert property (p_one_acc) // RL1
        else $error("ack without a request");
endmodule
`default_nettype wire

/* test/macu_core_model.sv */
// Purpose: Core-side model that issues one coprocessor request at a time
// Assumes: The unit acks every request it takes
// Notes:   Released operand lines show inverted data, never the old value
`timescale 1ns/1ps
`default_nettype none
module macu_core_model (
    input  wire logic                        core_clk,
    input  wire logic                        ack,
    output var  logic                        req_valid,
    output var  macu_pkg::macu_op_t          req_op,
    output var  logic [1:0]                  req_sel_hl,
    output var  logic [macu_pkg::WORD_W-1:0] req_a,
    output var  logic [macu_pkg::WORD_W-1:0] req_b
);
    import macu_pkg::*;
    initial begin
        req_valid = 1'b0;
        req_op = MACU_OP_HALF;
        req_sel_hl = 2'h0;
        req_a = '0;
        req_b = '0;
    end
    // Valid and operands stand until the edge at which ack is seen high
    task automatic issue(input macu_op_t op, input logic [1:0] sel, input logic [WORD_W-1:0] a,
                         input logic [WORD_W-1:0] b, input int gap, output int lat);
        repeat (gap + 1) @(posedge core_clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_sel_hl <= sel;
        req_a <= a;
        req_b <= b;
        lat = -1;
        do begin
            @(posedge core_clk);
            lat++;
        end while (ack !== 1'b1 && lat < 8);
        req_valid <= 1'b0;
        req_a <= ~a;
        req_b <= ~b;
    endtask
endmodule
`default_nettype wire

/* test/macu_top_tb.sv */
// Purpose: Self-checking bench for the multiply-accumulate unit
// Assumes: Core model drives all request inputs
// Notes:   Expected accumulator kept by the bench itself
`timescale 1ns/1ps
`default_nettype none
module macu_top_tb;
    import macu_pkg::*;
    logic              core_clk, rst, req_valid, ack;
    macu_op_t          req_op;
    logic [1:0]        req_sel_hl;
    logic [WORD_W-1:0] req_a, req_b, rd_lo, rd_hi, xfer_data;
    logic [ACC_W-1:0]  acc_out, ex;
    int                mismatches = 0;
    int                cmp_count = 0;
    int                lat;
    macu_core_model core (.core_clk(core_clk), .ack(ack), .req_valid(req_valid),
        .req_op(req_op), .req_sel_hl(req_sel_hl), .req_a(req_a), .req_b(req_b));
    macu_top dut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
        .req_sel_hl(req_sel_hl), .req_a(req_a), .req_b(req_b), .ack(ack), .rd_lo(rd_lo),
        .rd_hi(rd_hi), .xfer_data(xfer_data), .acc_out(acc_out));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic run(input macu_op_t op, input logic [1:0] s, input logic [31:0] a, b, int g);
        core.issue(op, s, a, b, g, lat);
        if (lat >= 8) begin
            mismatches++;
            end_sim();
        end
    endtask
    function automatic logic [ACC_W-1:0] mul(input logic signed [WORD_W-1:0] x, y);
        logic signed [ACC_W-1:0] p;
        p = x * y;
        return p;
    endfunction
    task automatic t_half;
        logic [15:0] xa, xb;
        run(MACU_OP_FROM_CORE, 2'h0, 32'h0000_0010, 32'h0000_00FF, 0);
        ex = 40'hFF_0000_0010;
        chk("acc load", acc_out, ex);
        for (int s = 0; s < 4; s++) begin
            xa = s[1] ? 16'h8000 : 16'h7FFF;
            xb = s[0] ? 16'hFFFE : 16'h0003;
            ex = ex + mul(32'($signed(xa)), 32'($signed(xb)));
            run(MACU_OP_HALF, 2'(s), 32'h8000_7FFF, 32'hFFFE_0003, s);
            chk("half lat", 64'(lat), 64'h1);
            chk("half acc", acc_out, ex);
        end
        $display("done half");
    endtask
    task automatic t_dual;
        ex = ex + mul(32'hFFFF_8000, 32'hFFFF_8000) + mul(32'h0000_1234, 32'hFFFF_FFFF);
        run(MACU_OP_DUAL, 2'h0, 32'h8000_1234, 32'h8000_FFFF, 0);
        chk("dual acc", acc_out, ex);
        ex = ex + mul(32'hFFFF_8000, 32'h7FFF_FFFF);
        run(MACU_OP_WORD, 2'h0, 32'hFFFF_8000, 32'h7FFF_FFFF, 0);
        chk("word16 lat", 64'(lat), 64'h1);
        chk("word16 acc", acc_out, ex);
        ex = ex + mul(32'h7FFF_FFFF, 32'h7FFF_FFFF);
        run(MACU_OP_WORD, 2'h0, 32'h7FFF_FFFF, 32'h7FFF_FFFF, 2);
        chk("word lat", 64'(lat), 64'(SLOW_CYCLES));
        chk("word acc", acc_out, ex);
        $display("done dual and word");
    endtask
    task automatic t_wrap;
        run(MACU_OP_FROM_CORE, 2'h0, 32'hFFFF_FFFF, 32'h0000_007F, 0);
        run(MACU_OP_HALF, 2'h0, 32'h0000_0001, 32'h0000_0001, 0);
        chk("wrap pos", acc_out, 40'h80_0000_0000);
        run(MACU_OP_FROM_CORE, 2'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 0);
        run(MACU_OP_HALF, 2'h0, 32'h0000_0001, 32'h0000_0001, 0);
        chk("wrap zero", acc_out, 40'h00_0000_0000);
        $display("done wrap");
    endtask
    task automatic t_move;
        run(MACU_OP_FROM_CORE, 2'h0, 32'h89AB_CDEF, 32'h1234_5680, 0);
        chk("acc pair", acc_out, 40'h80_89AB_CDEF);
        run(MACU_OP_TO_CORE, 2'h0, 32'h0, 32'h0, 1);
        chk("rd lo", rd_lo, 32'h89AB_CDEF);
        chk("rd hi", rd_hi, 32'hFFFF_FF80);
        run(MACU_OP_STORE, 2'h0, 32'h0, 32'h0, 0);
        chk("store lo", xfer_data, 32'h89AB_CDEF);
        run(MACU_OP_STORE, 2'h0, 32'h0, 32'h0, 0);
        chk("store hi", xfer_data, 32'hFFFF_FF80);
        run(MACU_OP_LOAD, 2'h0, 32'h1357_9BDF, 32'h0, 0);
        run(MACU_OP_LOAD, 2'h0, 32'h0000_0042, 32'h0, 0);
        chk("load pair", acc_out, 40'h42_1357_9BDF);
        $display("done move");
    endtask
    task automatic t_reset;
        run(MACU_OP_FROM_CORE, 2'h0, 32'h0246_8ACE, 32'h0000_0055, 0);
        run(MACU_OP_STORE, 2'h0, 32'h0, 32'h0, 0);
        chk("store before reset", xfer_data, 32'h0246_8ACE);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk("mid reset acc", acc_out, 40'h0);
        chk("mid reset xfer", xfer_data, 32'h0);
        chk("mid reset ack", 64'(ack), 64'h0);
        chk("mid reset rd lo", rd_lo, 32'h0);
        chk("mid reset rd hi", rd_hi, 32'h0);
        run(MACU_OP_LOAD, 2'h0, 32'h1111_2222, 32'h0, 0);
        chk("phase after reset", acc_out, 40'h00_1111_2222);
        $display("done reset");
    endtask
    initial begin
        rst = 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        chk("reset acc", acc_out, 40'h0);
        chk("reset ack", 64'(ack), 64'h0);
        t_half();
        t_dual();
        t_wrap();
        t_move();
        t_reset();
        end_sim();
    end
endmodule
`default_nettype wire
